/* verilog/flash_protect_function_register.v */
`timescale 1ns/100ps
`include "flash_protect_consts.vh"


module flash_protect_function_register #(
    parameter       NUM_BLOCKS   = `BLOCKS_FULL,
    parameter [0:0] RST_DIS_DFLT = 1'b0,
    parameter [0:0] HAS_DED_RST  = 1'b1
) (
    // Clock and reset
    input  wire                  clk_i,
    input  wire                  rst_n_i,
    // APB slave
    input  wire                  psel_i,
    input  wire                  penable_i,
    input  wire                  pwrite_i,
    input  wire [11:0]           paddr_i,
    input  wire [31:0]           pwdata_i,
    output wire                  pready_o,
    output wire                  pslverr_o,
    output reg  [31:0]           prdata_o,
    // Reset and hold pins
    input  wire                  ded_reset_n_i,
    input  wire                  shared_pin_i,
    output wire                  reset_req_o,
    output wire                  hold_active_o,
    // Protection and locks
    output wire [NUM_BLOCKS-1:0] protect_map_o,
    output wire [3:0]            info_row_lock_o,
    // Interrupt
    output wire                  irq_o
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [7:0]           func_reg;
    reg  [7:0]           func_next;
    reg  [6:0]           pcfg_reg;
    reg                  in_pgm_reg;
    reg                  in_ers_reg;
    reg  [3:0]           irq_stat_reg;
    reg  [3:0]           irq_stat_next;
    reg  [3:0]           irq_mask_reg;
    reg                  rst_cap_reg;

    wire                 wr_acc = psel_i && penable_i && pwrite_i;
    wire                 rd_acc = psel_i && penable_i && !pwrite_i;
    wire                 ev_wr  = wr_acc && paddr_i == `OFS_EVENT_CTRL;
    wire                 row_wr = wr_acc && paddr_i == `OFS_INFO_ROW_REQ;
    wire                 fr_wr  = wr_acc && paddr_i == `OFS_FUNC_REG;
    wire [3:0]           protect_level = pcfg_reg[3:0];
    wire                 half_array    = pcfg_reg[`PC_DENSITY_BIT];
    wire                 quad_lines_enable = pcfg_reg[`PC_QUAD_BIT];
    wire                 shared_pin_select = pcfg_reg[`PC_PINSEL_BIT];
    wire [NUM_BLOCKS-1:0] pmap;

    // ----------------------------------------
    // Suspend event and refused request decode
    // ----------------------------------------
    wire suspend_ev = ev_wr && pwdata_i[`EV_SUSPEND];
    wire resume_ev  = ev_wr && pwdata_i[`EV_RESUME];
    wire pgm_sus_set = suspend_ev && in_pgm_reg && !func_reg[`FR_PGM_SUS_BIT];
    wire ers_sus_set = suspend_ev && in_ers_reg && !func_reg[`FR_ERS_SUS_BIT];
    wire row_refused = row_wr && |(pwdata_i[3:0] & func_reg[7:4]);
    wire otp_refused = fr_wr && |(func_reg & `FR_OTP_MASK & ~pwdata_i[7:0]);

    // ----------------------------------------
    // Function register next state
    // ----------------------------------------
    always @* begin
        func_next = func_reg;
        if (fr_wr) begin
            // One-time bits only ever gain ones; suspend flags not writable
            func_next[7:4] = func_reg[7:4] | pwdata_i[7:4];
            func_next[`FR_SIDE_BIT] = func_reg[`FR_SIDE_BIT] | pwdata_i[`FR_SIDE_BIT];
            func_next[`FR_RST_DIS_BIT] = func_reg[`FR_RST_DIS_BIT] | pwdata_i[`FR_RST_DIS_BIT];
        end
        if (pgm_sus_set)
            func_next[`FR_PGM_SUS_BIT] = 1'b1;
        else if (resume_ev && func_reg[`FR_PGM_SUS_BIT])
            func_next[`FR_PGM_SUS_BIT] = 1'b0;
        if (ers_sus_set)
            func_next[`FR_ERS_SUS_BIT] = 1'b1;
        else if (resume_ev && func_reg[`FR_ERS_SUS_BIT])
            func_next[`FR_ERS_SUS_BIT] = 1'b0;
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            func_reg[7:1] <= `FR_RESET_HI;
            func_reg[0]   <= RST_DIS_DFLT;
            rst_cap_reg   <= 1'b0;
        end else begin
            func_reg    <= func_next;
            rst_cap_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Operation tracking
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            in_pgm_reg <= 1'b0;
            in_ers_reg <= 1'b0;
        end else if (ev_wr) begin
            if (pwdata_i[`EV_DONE]) begin
                in_pgm_reg <= 1'b0;
                in_ers_reg <= 1'b0;
            end else if (pwdata_i[`EV_PGM_START]) begin
                in_pgm_reg <= 1'b1;
            end else if (pwdata_i[`EV_ERS_START]) begin
                in_ers_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Protect config register
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i)
            pcfg_reg <= 7'h00;
        else if (wr_acc && paddr_i == `OFS_PROTECT_CFG)
            pcfg_reg <= pwdata_i[6:0];
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire irq_rd = rd_acc && paddr_i == `OFS_IRQ_STATUS;

    always @* begin
        irq_stat_next = irq_rd ? 4'h0 : irq_stat_reg;
        if (pgm_sus_set)
            irq_stat_next[`IRQ_PGM_SUS] = 1'b1;
        if (ers_sus_set)
            irq_stat_next[`IRQ_ERS_SUS] = 1'b1;
        if (row_refused)
            irq_stat_next[`IRQ_ROW_REFUSED] = 1'b1;
        if (otp_refused)
            irq_stat_next[`IRQ_OTP_REFUSED] = 1'b1;
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_acc && paddr_i == `OFS_IRQ_MASK)
                irq_mask_reg <= pwdata_i[3:0];
        end
    end

    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    // ----------------------------------------
    // Protection decode
    // ----------------------------------------
    protect_decode #(
        .NUM_BLOCKS    (NUM_BLOCKS)
    ) u_decode (
        .level_i       (protect_level),
        .bottom_i      (func_reg[`FR_SIDE_BIT]),
        .half_i        (half_array),
        .protect_map_o (pmap)
    );

    assign protect_map_o   = pmap;
    assign info_row_lock_o = func_reg[7:4];

    // ----------------------------------------
    // Reset and hold pin routing
    // ----------------------------------------
    wire rst_moved  = func_reg[`FR_RST_DIS_BIT] || !HAS_DED_RST;
    wire pin_is_rst = rst_moved && !quad_lines_enable
                      && (shared_pin_select || (HAS_DED_RST && func_reg[`FR_RST_DIS_BIT]));
    // Dedicated part with bit zero clear keeps hold on the shared pin while quad lines are off
    wire pin_is_hold = !quad_lines_enable && !pin_is_rst;

    assign reset_req_o   = rst_cap_reg && (pin_is_rst ? !shared_pin_i
                            : (HAS_DED_RST && !func_reg[`FR_RST_DIS_BIT] && !ded_reset_n_i));
    assign hold_active_o = rst_cap_reg && pin_is_hold && !shared_pin_i;

    // ----------------------------------------
    // APB read and answer
    // ----------------------------------------
    // Map zero-extended to four words; a zero-width pad is avoided
    reg  [127:0] map_wide;

    always @* begin
        map_wide = 128'h0;
        map_wide[NUM_BLOCKS-1:0] = pmap;
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `OFS_FUNC_REG:       prdata_o <= {24'h000000, func_reg};
                `OFS_PROTECT_CFG:    prdata_o <= {25'h0000000, pcfg_reg};
                `OFS_PROTECT_MAP_LO: prdata_o <= map_wide[31:0];
                `OFS_PROTECT_MAP_HI: prdata_o <= map_wide[63:32];
                `OFS_PROTECT_MAP_X2: prdata_o <= map_wide[95:64];
                `OFS_PROTECT_MAP_X3: prdata_o <= map_wide[127:96];
                `OFS_PIN_STATUS:     prdata_o <= {28'h0000000, in_ers_reg, in_pgm_reg,
                                                  pin_is_hold, pin_is_rst};
                `OFS_IRQ_STATUS:     prdata_o <= {28'h0000000, irq_stat_next};
                `OFS_IRQ_MASK:       prdata_o <= {28'h0000000, irq_mask_reg};
                default:             prdata_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule // flash_protect_function_register

/* verilog/flash_protect_consts.vh */
`ifndef FLASH_PROTECT_CONSTS_VH
`define FLASH_PROTECT_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_FUNC_REG        12'h000
`define OFS_PROTECT_CFG     12'h004
`define OFS_EVENT_CTRL      12'h008
`define OFS_PROTECT_MAP_LO  12'h00c
`define OFS_PROTECT_MAP_HI  12'h010
`define OFS_INFO_ROW_REQ    12'h014
`define OFS_PIN_STATUS      12'h018
`define OFS_IRQ_STATUS      12'h01c
`define OFS_IRQ_MASK        12'h020
`define OFS_PROTECT_MAP_X2  12'h024
`define OFS_PROTECT_MAP_X3  12'h028

// ----------------------------------------
// Function register fields
// ----------------------------------------
`define FR_RST_DIS_BIT      0
`define FR_SIDE_BIT         1
`define FR_PGM_SUS_BIT      2
`define FR_ERS_SUS_BIT      3
`define FR_LOCK_LSB         4
`define FR_OTP_MASK         8'hf3
`define FR_RESET_HI         7'h00

// ----------------------------------------
// Protect config fields
// ----------------------------------------
`define PC_LEVEL_LSB        0
`define PC_DENSITY_BIT      4
`define PC_QUAD_BIT         5
`define PC_PINSEL_BIT       6

// ----------------------------------------
// Event control bits (write one to pulse)
// ----------------------------------------
`define EV_PGM_START        0
`define EV_ERS_START        1
`define EV_SUSPEND          2
`define EV_RESUME           3
`define EV_DONE             4

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_PGM_SUS         0
`define IRQ_ERS_SUS         1
`define IRQ_ROW_REFUSED     2
`define IRQ_OTP_REFUSED     3
`define IRQ_WIDTH           4

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define BLOCKS_FULL         128
`define BLOCKS_HALF         64

`endif

/* verilog/protect_decode.v */
`timescale 1ns/100ps
`include "flash_protect_consts.vh"

module protect_decode #(
    parameter NUM_BLOCKS = `BLOCKS_FULL
) (
    // Protect selection
    input  wire [3:0]            level_i,
    input  wire                  bottom_i,
    input  wire                  half_i,
    // Block map
    output wire [NUM_BLOCKS-1:0] protect_map_o
);

    // ----------------------------------------
    // Protected block count
    // ----------------------------------------
    reg [7:0] count;

    always @* begin
        count = 8'h00;
        if (half_i) begin
            if (level_i[3] || level_i == 4'h7)
                count = 8'h40;
            else if (level_i != 4'h0)
                count = 8'h01 << (level_i[2:0] - 3'h1);
        end else begin
            if (level_i[3])
                count = 8'h80;
            else if (level_i != 4'h0)
                count = 8'h01 << (level_i[2:0] - 3'h1);
        end
    end

    // ----------------------------------------
    // Per-block compare
    // ----------------------------------------
    genvar b;
    generate
        for (b = 0; b < NUM_BLOCKS; b = b + 1) begin : g_blk
            wire [31:0] idx_full = b;
            wire [7:0]  idx      = idx_full[7:0];
            wire [7:0] last = half_i ? 8'h3f : 8'h7f;
            wire       in_r = half_i ? (b < `BLOCKS_HALF) : 1'b1;
            // Top counts down from last block, bottom up from block 0
            assign protect_map_o[b] = in_r && (bottom_i ? (idx < count)
                                                        : ((last - idx) < count));
        end
    endgenerate

endmodule // protect_decode

/* dv/flash_protect_props.sv */
`timescale 1ns/100ps
`include "flash_protect_consts.vh"
module flash_protect_props #(
    parameter NUM_BLOCKS = `BLOCKS_FULL
) (
    // Clock and reset
    input wire                  clk_i,
    input wire                  rst_n_i,
    // APB
    input wire                  psel_i,
    input wire                  penable_i,
    input wire                  pwrite_i,
    input wire [11:0]           paddr_i,
    input wire [31:0]           pwdata_i,
    input wire                  pready_o,
    input wire                  pslverr_o,
    // Pins and outputs
    input wire                  shared_pin_i,
    input wire                  hold_active_o,
    input wire [NUM_BLOCKS-1:0] protect_map_o,
    input wire [3:0]            info_row_lock_o,
    input wire                  irq_o
);
    wire wr_acc = psel_i && penable_i && pwrite_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_ready; psel_i && penable_i |-> pready_o && !pslverr_o; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_lock_rst; $rose(rst_n_i) |-> info_row_lock_o == 4'h0; endproperty
    a_lock_rst: assert property (p_lock_rst) else $error("locks not clear after reset");
    property p_lock_keep; $past(rst_n_i) |-> ($past(info_row_lock_o) & ~info_row_lock_o) == 4'h0; endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock bit returned to zero");
    property p_lock_wr;
        wr_acc && paddr_i == `OFS_FUNC_REG |=> info_row_lock_o == ($past(info_row_lock_o) | $past(pwdata_i[7:4]));
    endproperty
    a_lock_wr: assert property (p_lock_wr) else $error("lock bits not set by write");
    property p_none; wr_acc && paddr_i == `OFS_PROTECT_CFG && pwdata_i[3:0] == 4'h0 |=> protect_map_o == 0; endproperty
    a_none: assert property (p_none) else $error("level zero protects blocks");
    property p_all_full; wr_acc && paddr_i == `OFS_PROTECT_CFG && pwdata_i[3] && !pwdata_i[4] |=> &protect_map_o;
    endproperty
    a_all_full: assert property (p_all_full) else $error("top level not all blocks");
    property p_all_half;
        wr_acc && paddr_i == `OFS_PROTECT_CFG && pwdata_i[4] && pwdata_i[2:0] == 3'h7 |=> &protect_map_o[63:0];
    endproperty
    a_all_half: assert property (p_all_half) else $error("half array not all blocks");
    property p_hold; hold_active_o |-> !shared_pin_i; endproperty
    a_hold: assert property (p_hold) else $error("hold without pin low");
    property p_mask; wr_acc && paddr_i == `OFS_IRQ_MASK && pwdata_i[3:0] == 4'h0 |=> !irq_o; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt raised");
endmodule // flash_protect_props

bind flash_protect_function_register flash_protect_props #(.NUM_BLOCKS(NUM_BLOCKS)) i_flash_protect_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .shared_pin_i(shared_pin_i), .hold_active_o(hold_active_o), .protect_map_o(protect_map_o),
    .info_row_lock_o(info_row_lock_o), .irq_o(irq_o));

/* dv/apb_host_model.sv */
`timescale 1ns/100ps
module apb_host_model (
    // Clock
    input  wire        clk_i,
    // APB master
    output reg         psel_o,
    output reg         penable_o,
    output reg         pwrite_o,
    output reg  [11:0] paddr_o,
    output reg  [31:0] pwdata_o,
    input  wire        pready_i,
    input  wire [31:0] prdata_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
    end
    // One transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        q = prdata_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule // apb_host_model

/* dv/flash_protect_function_register_tb.sv */
`timescale 1ns/100ps
`include "flash_protect_consts.vh"
module flash_protect_function_register_tb;
    logic         clk_i, rst_n_i, ded_reset_n_i, shared_pin_i;
    wire          psel, penable, pwrite, pready, reset_req, hold_active, irq;
    wire  [11:0]  paddr;
    wire  [31:0]  pwdata, prdata;
    wire  [127:0] pmap;
    wire  [3:0]   locks;
    logic [31:0]  rd;
    int           failures, n_compared, cycles;

    flash_protect_function_register i_flash_protect_function_register (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(), .prdata_o(prdata),
        .ded_reset_n_i(ded_reset_n_i), .shared_pin_i(shared_pin_i), .reset_req_o(reset_req),
        .hold_active_o(hold_active), .protect_map_o(pmap), .info_row_lock_o(locks), .irq_o(irq));
    apb_host_model i_apb_host_model (
        .clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .pready_i(pready), .prdata_i(prdata));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test;
        end
    end

    task check(input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        i_apb_host_model.xfer(1'b1, a, d, rd);
    endtask
    task rdr(input logic [11:0] a);
        i_apb_host_model.xfer(1'b0, a, 32'h0, rd);
    endtask
    function logic [127:0] exp_map(input logic [3:0] lv, input logic bot, input logic half);
        int nb;
        int cnt;
        nb = half ? 64 : 128;
        cnt = (lv[3] || (half && lv == 4'h7)) ? nb : (lv == 4'h0 ? 0 : 1 << (lv - 1));
        exp_map = ((128'h1 << cnt) - 128'h1) << (bot ? 0 : nb - cnt);
    endfunction

    task test_reset;
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h0);
        check(locks, 4'h0);
        rdr(12'h02c);
        check(rd, 32'h0);
        $display("reset test done");
    endtask
    task test_suspend;
        wr(`OFS_IRQ_MASK, 32'hf);
        wr(`OFS_EVENT_CTRL, 32'h4);
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h0);
        wr(`OFS_EVENT_CTRL, 32'h1);
        wr(`OFS_EVENT_CTRL, 32'h4);
        wr(`OFS_FUNC_REG, 32'h0);
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h4);
        check(irq, 1'b1);
        wr(`OFS_EVENT_CTRL, 32'h8);
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h0);
        rdr(`OFS_IRQ_STATUS);
        check(rd, 32'h1);
        check(irq, 1'b0);
        wr(`OFS_EVENT_CTRL, 32'h10);
        wr(`OFS_IRQ_MASK, 32'h0);
        wr(`OFS_EVENT_CTRL, 32'h2);
        wr(`OFS_EVENT_CTRL, 32'h4);
        wr(`OFS_FUNC_REG, 32'hc);
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h8);
        check(irq, 1'b0);
        wr(`OFS_IRQ_MASK, 32'hf);
        check(irq, 1'b1);
        wr(`OFS_EVENT_CTRL, 32'h8);
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h0);
        rdr(`OFS_IRQ_STATUS);
        check(rd, 32'h2);
        wr(`OFS_EVENT_CTRL, 32'h10);
        $display("suspend test done");
    endtask
    task test_map;
        for (int s = 0; s < 4; s++) begin
            if (s == 2) wr(`OFS_FUNC_REG, 32'h2);
            for (int lv = 0; lv < 16; lv++) begin
                wr(`OFS_PROTECT_CFG, {27'h0, s[0], lv[3:0]});
                check(pmap & (s[0] ? {64'h0, {64{1'b1}}} : {128{1'b1}}),
                      exp_map(lv[3:0], s[1], s[0]));
            end
        end
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h2);
        $display("protect map test done");
    endtask
    task test_otp;
        shared_pin_i <= 1'b0;
        @(posedge clk_i);
        check({hold_active, reset_req}, 2'h2);
        wr(`OFS_FUNC_REG, 32'h30);
        check(locks, 4'h3);
        wr(`OFS_FUNC_REG, 32'h0);
        rdr(`OFS_FUNC_REG);
        check(rd, 32'h32);
        rdr(`OFS_IRQ_STATUS);
        check(rd, 32'h8);
        wr(`OFS_INFO_ROW_REQ, 32'h1);
        rdr(`OFS_IRQ_STATUS);
        check(rd, 32'h4);
        wr(`OFS_INFO_ROW_REQ, 32'h4);
        rdr(`OFS_IRQ_STATUS);
        check(rd, 32'h0);
        wr(`OFS_FUNC_REG, 32'h1);
        check({hold_active, reset_req}, 2'h1);
        shared_pin_i <= 1'b1;
        ded_reset_n_i <= 1'b0;
        @(posedge clk_i);
        check(reset_req, 1'b0);
        $display("one-time bits test done");
    endtask

    task finish_test;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        rst_n_i = 1'b0;
        ded_reset_n_i = 1'b1;
        shared_pin_i = 1'b1;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        test_reset;
        test_suspend;
        test_map;
        test_otp;
        finish_test;
    end
endmodule // flash_protect_function_register_tb
